// [spb_map.vh]
// spb_map.vh: constants of the synchronous peripheral bus cycle block
// assumes inclusion by bare name from the design file only
`ifndef SPB_MAP_VH
`define SPB_MAP_VH

// bus state numbers, one per half system clock
`define SPB_ST_ADDR      4'h0
`define SPB_ST_STROBE    4'h2
`define SPB_ST_WDATA     4'h3
`define SPB_ST_4         4'h4
`define SPB_ST_DECIDE    4'h5
`define SPB_ST_6         4'h6
`define SPB_ST_7         4'h7
// autovector number = base + serviced level
`define SPB_AUTO_VECTOR_REQ_N_BASE    8'h18
// reset values
`define SPB_RST_PINS     9'h1ff
`define SPB_RST_VEC      8'h00
// read/write line levels
`define SPB_RW_READ      1'b1
`define SPB_RW_WRITE     1'b0

`endif

// [spb_sync_periph_bus.v]
// spb_sync_periph_bus.v: processor side of asynchronous and synchronous peripheral bus cycles
// assumes clk_in runs at twice the emulated system clock, one bus state per clk_in cycle;
// all pin inputs and the enable clock arrive asynchronously
`timescale 1ns/1ns
`default_nettype none
`include "spb_map.vh"

module spb_sync_periph_bus #(
  parameter AW = 23,
  parameter DW = 16
) (
  input  wire          clk_in,
  input  wire          sys_rst_in,
  input  wire          start_in,
  input  wire          start_rd_in,
  input  wire          start_iack_in,
  input  wire [AW:1]   start_addr_in,
  input  wire [DW-1:0] start_wdata_in,
  input  wire [DW-1:0] data_pin_in,
  input  wire          e_clk_in,
  input  wire [2:0]    irq_level_n_in,
  input  wire          auto_vector_req_n_in,
  input  wire          bus_request_n_in,
  input  wire          bus_error_n_in,
  input  wire          grant_ack_n_in,
  input  wire          transfer_ack_n_in,
  input  wire          sync_periph_request_n_in,
  output reg  [AW:1]   addr_out,
  output reg           addr_oe_out,
  output reg  [DW-1:0] data_out,
  output reg           data_oe_out,
  output reg           rw_out,
  output reg           ctl_oe_out,
  output reg           addr_strobe_n_out,
  output reg           data_strobe_n_out,
  output reg           periph_addr_valid_n_out,
  output reg           busy_out,
  output reg           done_out,
  output reg           err_out,
  output reg  [DW-1:0] rdata_out,
  output reg  [7:0]    vector_out,
  output reg           autovec_out,
  output reg  [2:0]    irq_level_out,
  output reg           bus_req_seen_out
);

  localparam M_IDLE = 3'h0;
  localparam M_RUN  = 3'h1;
  localparam M_ELOW = 3'h2;
  localparam M_EHI  = 3'h3;
  localparam M_EFAL = 3'h4;

  // pin order: irq[2:0], auto_vector_req_n, br, bus_error_in_n, grant_ack_in_n, transfer_ack_n, vpa
  wire [8:0] pins_w = {irq_level_n_in, auto_vector_req_n_in, bus_request_n_in,
                       bus_error_n_in, grant_ack_n_in, transfer_ack_n_in, sync_periph_request_n_in};

  reg [8:0]    pin_s1_r;
  reg [8:0]    pin_s2_r;
  reg [8:0]    smp_r;
  reg          e_s1_r;
  reg          e_s2_r;
  reg [DW-1:0] d_s1_r;
  reg [DW-1:0] d_s2_r;
  reg [DW-1:0] d_hi_r;
  reg          ph_r;
  reg [2:0]    mode_r;
  reg [3:0]    st_r;
  reg          rd_r;
  reg          iack_r;
  reg [2:0]    lvl_r;

  wire smp_vpa   = ~smp_r[0];
  wire smp_transfer_ack_n = ~smp_r[1];
  wire smp_grant_ack_in_n = ~smp_r[2];
  wire smp_bus_error_in_n  = ~smp_r[3];
  wire smp_br    = ~smp_r[4];
  wire smp_auto_vector_req_n  = ~smp_r[5];
  wire [2:0] smp_lvl = ~smp_r[8:6];

  function [7:0] spb_autovec;
    input [2:0] lvl;
    begin
      spb_autovec = `SPB_AUTO_VECTOR_REQ_N_BASE + {5'h00, lvl};
    end
  endfunction

  // two-flop synchronisers, then falling-edge sampling; ph_r low is the clock's high half
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_s1_r <= `SPB_RST_PINS;
      pin_s2_r <= `SPB_RST_PINS;
      smp_r    <= `SPB_RST_PINS;
      e_s1_r   <= 1'b0;
      e_s2_r   <= 1'b0;
      d_s1_r   <= {DW{1'b0}};
      d_s2_r   <= {DW{1'b0}};
      d_hi_r   <= {DW{1'b0}};
      ph_r     <= 1'b0;
    end else begin
      pin_s1_r <= pins_w;
      pin_s2_r <= pin_s1_r;
      e_s1_r   <= e_clk_in;
      e_s2_r   <= e_s1_r;
      d_s1_r   <= data_pin_in;
      d_s2_r   <= d_s1_r;
      // data and enable share one sync depth, so this is the last word seen with enable high
      if (e_s2_r)
        d_hi_r <= d_s2_r;
      ph_r     <= ~ph_r;
      if (!ph_r)
        smp_r <= pin_s2_r;
    end
  end

  // bus cycle sequencer
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode_r                  <= M_IDLE;
      st_r                    <= `SPB_ST_ADDR;
      rd_r                    <= 1'b1;
      iack_r                  <= 1'b0;
      lvl_r                   <= 3'h0;
      addr_out                <= {AW{1'b0}};
      addr_oe_out             <= 1'b0;
      data_out                <= {DW{1'b0}};
      data_oe_out             <= 1'b0;
      rw_out                  <= `SPB_RW_READ;
      ctl_oe_out              <= 1'b0;
      addr_strobe_n_out       <= 1'b1;
      data_strobe_n_out       <= 1'b1;
      periph_addr_valid_n_out <= 1'b1;
      busy_out                <= 1'b0;
      done_out                <= 1'b0;
      err_out                 <= 1'b0;
      rdata_out               <= {DW{1'b0}};
      vector_out              <= `SPB_RST_VEC;
      autovec_out             <= 1'b0;
      irq_level_out           <= 3'h0;
      bus_req_seen_out        <= 1'b0;
    end else begin
      done_out      <= 1'b0;
      irq_level_out <= smp_lvl;
      case (mode_r)
        M_IDLE: begin
          // control lines float while an alternate master holds the bus
          ctl_oe_out <= ~smp_grant_ack_in_n;
          bus_req_seen_out <= smp_br;
          // starting on ph_r high puts bus state 0 in the clock's high half
          if (start_in && ph_r && !smp_grant_ack_in_n) begin
            mode_r      <= M_RUN;
            st_r        <= `SPB_ST_ADDR;
            busy_out    <= 1'b1;
            err_out     <= 1'b0;
            autovec_out <= 1'b0;
            rd_r        <= start_rd_in | start_iack_in;
            iack_r      <= start_iack_in;
            lvl_r       <= start_addr_in[3:1];
            addr_out    <= start_addr_in;
            addr_oe_out <= 1'b1;
            ctl_oe_out  <= 1'b1;
            rw_out      <= (start_rd_in | start_iack_in) ? `SPB_RW_READ : `SPB_RW_WRITE;
            data_out    <= start_wdata_in;
          end
        end
        M_RUN: begin
          st_r <= st_r + 4'h1;
          case (st_r)
            `SPB_ST_STROBE: begin
              addr_strobe_n_out <= 1'b0;
              if (rd_r)
                data_strobe_n_out <= 1'b0;
            end
            `SPB_ST_WDATA: begin
              if (!rd_r)
                data_oe_out <= 1'b1;
            end
            `SPB_ST_4: begin
              data_strobe_n_out <= 1'b0;
            end
            // terminations sampled at the falling edge ending state 4
            `SPB_ST_DECIDE: begin
              if (smp_bus_error_in_n) begin
                err_out           <= 1'b1;
                addr_strobe_n_out <= 1'b1;
                data_strobe_n_out <= 1'b1;
                st_r              <= `SPB_ST_7;
              end else if (smp_vpa) begin
                mode_r <= M_ELOW;
                if (iack_r) begin
                  vector_out  <= spb_autovec(lvl_r);
                  autovec_out <= 1'b1;
                end
              end else if (iack_r && smp_auto_vector_req_n) begin
                vector_out  <= spb_autovec(lvl_r);
                autovec_out <= 1'b1;
              end else if (!smp_transfer_ack_n) begin
                st_r <= `SPB_ST_4; // wait state pair
              end
            end
            `SPB_ST_6: begin
              if (rd_r && !autovec_out)
                rdata_out <= d_s2_r;
              if (iack_r && !autovec_out)
                vector_out <= d_s2_r[7:0];
              addr_strobe_n_out <= 1'b1;
              data_strobe_n_out <= 1'b1;
            end
            `SPB_ST_7: begin
              addr_oe_out      <= 1'b0;
              data_oe_out      <= 1'b0;
              rw_out           <= `SPB_RW_READ;
              mode_r           <= M_IDLE;
              busy_out         <= 1'b0;
              done_out         <= 1'b1;
              bus_req_seen_out <= smp_br;
            end
            default: begin
            end
          endcase
        end
        // peripheral cycle: whole clocks only, acting on the high-half boundary
        M_ELOW: begin
          if (!ph_r && !e_s2_r) begin
            periph_addr_valid_n_out <= 1'b0;
            mode_r                  <= M_EHI;
          end
        end
        M_EHI: begin
          if (e_s2_r)
            mode_r <= M_EFAL;
        end
        M_EFAL: begin
          // peripheral transfer happens while the enable clock is high
          if (!ph_r && !e_s2_r) begin
            // the synchronised fall comes after the peripheral has let go of the data
            if (rd_r && !autovec_out)
              rdata_out <= d_hi_r;
            addr_strobe_n_out       <= 1'b1;
            data_strobe_n_out       <= 1'b1;
            periph_addr_valid_n_out <= 1'b1;
            mode_r                  <= M_RUN;
            st_r                    <= `SPB_ST_7;
          end
        end
        default: begin
          mode_r <= M_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [spb_chk.sv]
// spb_chk.sv: assertions on the bus cycle block's pins
// assumes binding into spb_sync_periph_bus, one clock domain
`timescale 1ns/1ns
`default_nettype none
module spb_chk (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ctl_oe_out,
  input wire logic addr_oe_out,
  input wire logic rw_out,
  input wire logic addr_strobe_n_out,
  input wire logic data_strobe_n_out,
  input wire logic periph_addr_valid_n_out,
  input wire logic busy_out,
  input wire logic done_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_sel_on;
    $fell(periph_addr_valid_n_out);
  endsequence
  sequence s_sel_off;
    $rose(periph_addr_valid_n_out);
  endsequence
  a_sel_in_cycle: assert property (!periph_addr_valid_n_out |-> busy_out && !addr_strobe_n_out)
    else $error("select outside strobed cycle");
  a_sel_after_as: assert property (s_sel_on |-> !$past(addr_strobe_n_out))
    else $error("select before strobe");
  a_sel_bounded: assert property (s_sel_on |-> ##[1:40] s_sel_off)
    else $error("select never released");
  a_sel_drop_as: assert property (s_sel_off |-> $rose(addr_strobe_n_out))
    else $error("select and strobe not released together");
  a_strobes_pair: assert property ($rose(addr_strobe_n_out) |-> data_strobe_n_out)
    else $error("data strobe still low");
  a_float_after: assert property ($rose(addr_strobe_n_out) |=> !addr_oe_out && rw_out)
    else $error("bus not floated after strobe");
  a_done_idle: assert property (done_out |-> rw_out && !addr_oe_out && addr_strobe_n_out)
    else $error("bus driven at cycle end");
  a_float_nosel: assert property (!ctl_oe_out |-> periph_addr_valid_n_out)
    else $error("select while floated");
endmodule
`default_nettype wire

// [spb_periph.sv]
// spb_periph.sv: slow peripheral with its decode and free enable clock
// assumes the bench selects it by sel_in
`timescale 1ns/1ns
`default_nettype none
module spb_periph (
  input  wire logic        sel_in,
  input  wire logic        as_n_in,
  input  wire logic        vma_n_in,
  input  wire logic [15:0] pdat_in,
  output logic             e_out,
  output logic             req_n_out,
  output logic [15:0]      dat_out
);
  initial begin
    e_out = 0;
    #3;
    forever begin
      #63 e_out = 1;
      #62 e_out = 0;
    end
  end
  // released together with strobe, well inside one clock
  assign req_n_out = !(sel_in && !as_n_in);
  // data only while selected and enable high, else inverted
  assign dat_out = (!vma_n_in && e_out) ? pdat_in : ~pdat_in;
endmodule
`default_nettype wire

// [tb_top.sv]
// tb_top.sv: scenario bench for the bus cycle block
// assumes spb_periph as far side and spb_chk bound
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_in = 0, sys_rst_in = 1, start_in = 0, start_rd_in = 1, start_iack_in = 0, psel = 0;
  logic auto_vector_req_n_in = 1, bus_request_n_in = 1, bus_error_n_in = 1;
  logic grant_ack_n_in = 1, transfer_ack_n_in = 1;
  logic [22:0] start_addr_in = 23'h0;
  logic [15:0] start_wdata_in = 16'h1234, tdat = 16'h5a3c, pdat = 16'hc3a5;
  logic [2:0]  irq_level_n_in = 3'h7;
  wire logic e_clk_in, sync_periph_request_n_in, addr_strobe_n_out, periph_addr_valid_n_out;
  wire logic busy_out, done_out, err_out, autovec_out, bus_req_seen_out;
  wire logic [15:0] rdata_out, pout, data_pin_in;
  wire logic [7:0]  vector_out;
  wire logic [22:0] addr_out;
  wire logic [15:0] data_out;
  wire logic        data_oe_out, rw_out, ctl_oe_out;
  wire logic [2:0]  irq_level_out;
  logic [22:0] sel_addr = 23'h0;
  logic [15:0] sel_dat = 16'h0;
  logic        sel_wr = 0;
  int sel_cnt = 0;
  int err_total = 0, checks_done = 0, cyc = 0;
  assign data_pin_in = psel ? pout : tdat;
  spb_sync_periph_bus dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in), .start_rd_in(start_rd_in),
    .start_iack_in(start_iack_in), .start_addr_in(start_addr_in), .start_wdata_in(start_wdata_in),
    .data_pin_in(data_pin_in), .e_clk_in(e_clk_in), .irq_level_n_in(irq_level_n_in),
    .auto_vector_req_n_in(auto_vector_req_n_in), .bus_request_n_in(bus_request_n_in),
    .bus_error_n_in(bus_error_n_in), .grant_ack_n_in(grant_ack_n_in),
    .transfer_ack_n_in(transfer_ack_n_in), .sync_periph_request_n_in(sync_periph_request_n_in),
    .addr_out(addr_out), .addr_oe_out(), .data_out(data_out), .data_oe_out(data_oe_out),
    .rw_out(rw_out), .ctl_oe_out(ctl_oe_out), .addr_strobe_n_out(addr_strobe_n_out),
    .data_strobe_n_out(), .periph_addr_valid_n_out(periph_addr_valid_n_out),
    .busy_out(busy_out), .done_out(done_out), .err_out(err_out), .rdata_out(rdata_out),
    .vector_out(vector_out), .autovec_out(autovec_out), .irq_level_out(irq_level_out),
    .bus_req_seen_out(bus_req_seen_out));
  spb_periph u_per (.sel_in(psel), .as_n_in(addr_strobe_n_out), .vma_n_in(periph_addr_valid_n_out),
    .pdat_in(pdat), .e_out(e_clk_in), .req_n_out(sync_periph_request_n_in), .dat_out(pout));
  initial forever #4 clk_in = ~clk_in;
  // what the bus shows while the peripheral is selected
  always @(negedge clk_in)
    if (!periph_addr_valid_n_out) begin
      sel_cnt  <= sel_cnt + 1;
      sel_addr <= addr_out;
      sel_dat  <= data_out;
      sel_wr   <= data_oe_out & ~rw_out;
    end
  task automatic finish_test;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic run(input logic rd, input logic ia, input logic [22:0] a);
    int n;
    @(negedge clk_in);
    start_in = 1; start_rd_in = rd; start_iack_in = ia; start_addr_in = a;
    n = 0;
    while (busy_out !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    start_in = 0;
    n = 0;
    while (done_out !== 1'b1 && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    chk({15'h0, done_out}, 16'h1);
  endtask
  task automatic t_async;
    transfer_ack_n_in = 0;
    run(1, 0, 23'h100);
    transfer_ack_n_in = 1;
    chk(rdata_out, tdat);
    chk({15'h0, err_out}, 16'h0);
  endtask
  task automatic t_bus_error_in_n;
    bus_error_n_in = 0;
    run(1, 0, 23'h104);
    bus_error_n_in = 1;
    chk({15'h0, err_out}, 16'h1);
  endtask
  task automatic t_periph;
    int n0;
    psel = 1;
    bus_request_n_in = 0;
    n0 = sel_cnt;
    run(1, 0, 23'h200);
    chk(rdata_out, pdat);
    chk({15'h0, bus_req_seen_out}, 16'h1);
    chk({15'h0, sel_cnt > n0}, 16'h1);
    chk(sel_addr[15:0], 16'h0200);
    chk({15'h0, sel_wr}, 16'h0);
    bus_request_n_in = 1;
    n0 = sel_cnt;
    run(0, 0, 23'h202);
    chk({15'h0, sel_cnt > n0}, 16'h1);
    chk(sel_addr[15:0], 16'h0202);
    chk(sel_dat, start_wdata_in);
    chk({15'h0, sel_wr}, 16'h1);
    chk({15'h0, bus_req_seen_out}, 16'h0);
  endtask
  task automatic t_iack;
    for (int l = 1; l < 8; l++) begin
      irq_level_n_in = ~l[2:0];
      run(1, 1, {20'h0, l[2:0]});
      chk({8'h0, vector_out}, 16'h18 + l[15:0]);
      chk({15'h0, autovec_out}, 16'h1);
      chk({13'h0, irq_level_out}, l[15:0]);
    end
    psel = 0;
    auto_vector_req_n_in = 0;
    run(1, 1, 23'h5);
    auto_vector_req_n_in = 1;
    chk({8'h0, vector_out}, 16'h1d);
    chk({15'h0, autovec_out}, 16'h1);
    transfer_ack_n_in = 0;
    run(1, 1, 23'h3);
    transfer_ack_n_in = 1;
    chk({8'h0, vector_out}, {8'h0, tdat[7:0]});
    chk({15'h0, autovec_out}, 16'h0);
  endtask
  task automatic t_grant;
    grant_ack_n_in = 0;
    repeat (8) @(negedge clk_in);
    chk({15'h0, ctl_oe_out}, 16'h0);
    start_in = 1;
    repeat (6) @(negedge clk_in);
    chk({15'h0, busy_out}, 16'h0);
    chk({15'h0, periph_addr_valid_n_out}, 16'h1);
    start_in = 0;
    grant_ack_n_in = 1;
    repeat (8) @(negedge clk_in);
    chk({15'h0, ctl_oe_out}, 16'h1);
  endtask
  initial begin
    repeat (6) @(negedge clk_in);
    sys_rst_in = 0;
    t_async;
    t_bus_error_in_n;
    t_periph;
    t_iack;
    t_grant;
    finish_test;
  end
  // cuts a hang short well past the expected run
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test;
    end
  end
endmodule
bind spb_sync_periph_bus spb_chk u_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ctl_oe_out(ctl_oe_out), .addr_oe_out(addr_oe_out),
  .rw_out(rw_out), .addr_strobe_n_out(addr_strobe_n_out), .data_strobe_n_out(data_strobe_n_out),
  .periph_addr_valid_n_out(periph_addr_valid_n_out), .busy_out(busy_out), .done_out(done_out));
`default_nettype wire
